// file: src/vpru_defs.vh
// constants for the virtual page relocation unit
`ifndef VPRU_DEFS_VH
`define VPRU_DEFS_VH

// register byte addresses on the control bus
`define VPRU_BASE_OFS 12'h000
`define VPRU_DESC_OFS 12'h200
`define VPRU_CTRL_OFS 12'h400
`define VPRU_EXT_OFS 12'h404
`define VPRU_STAT_OFS 12'h408
`define VPRU_FVA_OFS 12'h40C
`define VPRU_TBL_MSB 11
`define VPRU_TBL_LSB 9
`define VPRU_NREGS 48

// abort and trap vector, octal 250
`define VPRU_VECTOR 16'h00A8

// virtual address fields
`define VPRU_PAGE_MSB 15
`define VPRU_PAGE_LSB 13
`define VPRU_BLK_MSB 12
`define VPRU_BLK_LSB 6
`define VPRU_DIB_MSB 5
`define VPRU_DIB_LSB 0

// descriptor fields
`define VPRU_PLF_MSB 14
`define VPRU_PLF_LSB 8
`define VPRU_ACC_BIT 7
`define VPRU_WR_BIT 6
`define VPRU_ED_BIT 3
`define VPRU_KEY_MSB 2
`define VPRU_KEY_LSB 0

// control and extension bits
`define VPRU_CTRL_EN 0
`define VPRU_EXT_22 4
`define VPRU_EXT_DK 2
`define VPRU_EXT_DS 1
`define VPRU_EXT_DU 0

// abort status fields
`define VPRU_ST_KEY 15
`define VPRU_ST_LEN 14
`define VPRU_ST_RO 13
`define VPRU_ST_TRAP 12
`define VPRU_ST_MODE_MSB 6
`define VPRU_ST_MODE_LSB 5
`define VPRU_ST_DSP 4
`define VPRU_ST_PAGE_MSB 3
`define VPRU_ST_PAGE_LSB 1

// processor modes
`define VPRU_MODE_KERN 2'h0
`define VPRU_MODE_SUPV 2'h1
`define VPRU_MODE_USER 2'h3

// access key outcomes
`define VPRU_ACC_OK 2'h0
`define VPRU_ACC_TRAP 2'h1
`define VPRU_ACC_KEYAB 2'h2
`define VPRU_ACC_ROAB 2'h3

// 18-bit mapping range and system bus window
`define VPRU_PA18_MASK 22'h03FFFF
`define VPRU_BUS_TOP 4'hF
`define VPRU_PP_TOP 6'h3F

// bus responses
`define VPRU_RESP_OK 2'h0
`define VPRU_RESP_ERR 2'h2

`endif

// file: src/vpru_top.v
// virtual page relocation unit with control-bus register file
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "vpru_defs.vh"

module vpru_top
(
	// clock and reset
	input wire clk,
	input wire arst_n,
	// processor reference
	input wire cpu_req,
	input wire [15:0] cpu_vaddr,
	input wire [1:0] cpu_mode,
	input wire cpu_ispace,
	input wire cpu_write,
	input wire cpu_instr_end,
	// translated reference
	output reg [21:0] phys_addr,
	output reg mem_req,
	output reg bus_req,
	output reg ref_write,
	// fault reporting
	output reg abort,
	output reg trap,
	output reg [15:0] fault_vector,
	// axi4-lite write address
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// access key decode: three keys trap, others abort or pass
	function [1:0] key_outcome;
		input [2:0] key;
		input wr;
		begin
			case (key)
				3'h1: key_outcome = wr ? `VPRU_ACC_ROAB : `VPRU_ACC_TRAP;
				3'h2: key_outcome = wr ? `VPRU_ACC_ROAB : `VPRU_ACC_OK;
				3'h4: key_outcome = `VPRU_ACC_TRAP;
				3'h5: key_outcome = wr ? `VPRU_ACC_TRAP : `VPRU_ACC_OK;
				3'h6: key_outcome = `VPRU_ACC_OK;
				default: key_outcome = `VPRU_ACC_KEYAB;
			endcase
		end
	endfunction

	// byte-lane merge of a 16-bit register with bus write data
	function [15:0] lane_merge;
		input [15:0] old;
		input [31:0] wd;
		input [3:0] st;
		begin
			lane_merge[7:0] = st[0] ? wd[7:0] : old[7:0];
			lane_merge[15:8] = st[1] ? wd[15:8] : old[15:8];
		end
	endfunction

	// table entry index is valid below the count with bit 8 clear;
	// without the bit 8 test the gap between tables would alias entries
	function idx_in_range;
		input [11:0] addr;
		begin
			idx_in_range = ~addr[8] && (addr[7:2] < `VPRU_NREGS);
		end
	endfunction

	// register storage
	reg [15:0] base_mem [0:`VPRU_NREGS-1];
	reg [15:0] desc_mem [0:`VPRU_NREGS-1];
	reg [15:0] ctrl_r;
	reg [15:0] ext_r;
	reg [15:0] stat_r;
	reg [15:0] fva_r;
	reg trap_pend_r;
	integer i;

	// register selection for the current reference
	reg [1:0] mode_idx;
	reg dsel;
	reg [5:0] ridx;
	reg [15:0] sel_base;
	reg [15:0] sel_desc;
	reg [15:0] phys_blk;
	reg [21:0] pa_full;
	reg [21:0] pa_nxt;
	reg len_bad;
	reg [1:0] acc;
	reg do_abort;
	reg do_trap;
	wire [2:0] vpage = cpu_vaddr[`VPRU_PAGE_MSB:`VPRU_PAGE_LSB];
	wire [6:0] vblk = cpu_vaddr[`VPRU_BLK_MSB:`VPRU_BLK_LSB];
	wire [5:0] vdib = cpu_vaddr[`VPRU_DIB_MSB:`VPRU_DIB_LSB];
	wire reloc_en = ctrl_r[`VPRU_CTRL_EN];
	wire map22 = ext_r[`VPRU_EXT_22];
	wire frozen = stat_r[`VPRU_ST_KEY] | stat_r[`VPRU_ST_LEN] |
		stat_r[`VPRU_ST_RO];

	// mode and space pick the group of eight, page picks the pair
	always @*
	begin
		case (cpu_mode)
			`VPRU_MODE_KERN: mode_idx = 2'h0;
			`VPRU_MODE_SUPV: mode_idx = 2'h1;
			default: mode_idx = 2'h2;
		endcase
		// data space only where the mode's extension bit allows it
		case (mode_idx)
			2'h0: dsel = ~cpu_ispace & ext_r[`VPRU_EXT_DK];
			2'h1: dsel = ~cpu_ispace & ext_r[`VPRU_EXT_DS];
			default: dsel = ~cpu_ispace & ext_r[`VPRU_EXT_DU];
		endcase
		ridx = {mode_idx, dsel, vpage};
		sel_base = base_mem[ridx];
		sel_desc = desc_mem[ridx];
		// base counts 32-word blocks; add virtual block number
		phys_blk = sel_base + {9'h000, vblk};
		pa_full = {phys_blk, vdib};
		// length check against the page length field
		if (sel_desc[`VPRU_ED_BIT])
			len_bad = vblk < sel_desc[`VPRU_PLF_MSB:`VPRU_PLF_LSB];
		else
			len_bad = vblk > sel_desc[`VPRU_PLF_MSB:`VPRU_PLF_LSB];
		acc = key_outcome(sel_desc[`VPRU_KEY_MSB:`VPRU_KEY_LSB], cpu_write);
		do_abort = cpu_req & reloc_en &
			(len_bad | acc == `VPRU_ACC_KEYAB | acc == `VPRU_ACC_ROAB);
		do_trap = cpu_req & reloc_en & ~do_abort & acc == `VPRU_ACC_TRAP;
		// mapping width from the control and extension bits
		if (!reloc_en)
		begin
			if (vpage == 3'h7)
				pa_nxt = {`VPRU_PP_TOP, cpu_vaddr};
			else
				pa_nxt = {6'h00, cpu_vaddr};
		end
		else if (map22)
			pa_nxt = pa_full;
		else if (pa_full[17:13] == 5'h1F)
			pa_nxt = pa_full | ~`VPRU_PA18_MASK;
		else
			pa_nxt = pa_full & `VPRU_PA18_MASK;
	end

	// translated reference; an aborted one raises no request
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phys_addr <= 22'h000000;
			mem_req <= 1'b0;
			bus_req <= 1'b0;
			ref_write <= 1'b0;
			abort <= 1'b0;
			fault_vector <= 16'h0000;
		end
		else
		begin
			phys_addr <= pa_nxt;
			ref_write <= cpu_write;
			// top four bits all ones route to the system bus
			bus_req <= cpu_req & ~do_abort &
				(pa_nxt[21:18] == `VPRU_BUS_TOP);
			mem_req <= cpu_req & ~do_abort &
				(pa_nxt[21:18] != `VPRU_BUS_TOP);
			abort <= do_abort;
			if (do_abort | (trap_pend_r & cpu_instr_end))
				fault_vector <= `VPRU_VECTOR;
		end
	end

	// trap waits for the end of the instruction; a new trap in the same cycle wins over the clear
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			trap_pend_r <= 1'b0;
			trap <= 1'b0;
		end
		else
		begin
			trap <= trap_pend_r & cpu_instr_end;
			if (do_trap)
				trap_pend_r <= 1'b1;
			else if (cpu_instr_end)
				trap_pend_r <= 1'b0;
		end
	end

	// bus handshakes: write takes address and data together
	wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = ~s_axi_rvalid;
	wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
	wire wtbl_hit = s_axi_awaddr[`VPRU_TBL_MSB:`VPRU_TBL_LSB] == 3'h0 ||
		s_axi_awaddr[`VPRU_TBL_MSB:`VPRU_TBL_LSB] == 3'h1;
	wire [5:0] widx = s_axi_awaddr[7:2];
	wire wbase = wr_go & s_axi_awaddr[`VPRU_TBL_MSB:`VPRU_TBL_LSB] == 3'h0;
	wire wdesc = wr_go & s_axi_awaddr[`VPRU_TBL_MSB:`VPRU_TBL_LSB] == 3'h1;
	wire widx_ok = idx_in_range(s_axi_awaddr);
	wire wstat = wr_go & s_axi_awaddr == `VPRU_STAT_OFS;
	wire hw_ref = cpu_req & reloc_en & ~do_abort;

	// page tables: hardware status sets win over a software write to the same entry; a write to another descriptor drops them
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (i = 0; i < `VPRU_NREGS; i = i + 1)
			begin
				base_mem[i] <= 16'h0000;
				desc_mem[i] <= 16'h0000;
			end
		end
		else
		begin
			if (wbase & widx_ok)
				base_mem[widx] <= lane_merge(base_mem[widx], s_axi_wdata,
					s_axi_wstrb);
			if (wdesc & widx_ok & ~(hw_ref & widx == ridx))
				desc_mem[widx] <= lane_merge(desc_mem[widx], s_axi_wdata,
					s_axi_wstrb);
			else if (hw_ref)
			begin
				desc_mem[ridx][`VPRU_ACC_BIT] <= 1'b1;
				if (cpu_write)
					desc_mem[ridx][`VPRU_WR_BIT] <= 1'b1;
			end
			// same-entry collision: merge software value, keep hw sets
			if (wdesc & widx_ok & hw_ref & widx == ridx)
				desc_mem[widx] <= lane_merge(desc_mem[widx], s_axi_wdata,
					s_axi_wstrb) | ({15'h0000, 1'b1} << `VPRU_ACC_BIT) |
					({15'h0000, cpu_write} << `VPRU_WR_BIT);
		end
	end

	// control, extension and abort status registers
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_r <= 16'h0000;
			ext_r <= 16'h0000;
			stat_r <= 16'h0000;
			fva_r <= 16'h0000;
		end
		else
		begin
			if (wr_go & s_axi_awaddr == `VPRU_CTRL_OFS)
				ctrl_r <= lane_merge(ctrl_r, s_axi_wdata, s_axi_wstrb);
			if (wr_go & s_axi_awaddr == `VPRU_EXT_OFS)
				ext_r <= lane_merge(ext_r, s_axi_wdata, s_axi_wstrb);
			// first abort is held until software clears the flags
			if (do_abort & ~frozen)
			begin
				stat_r[`VPRU_ST_KEY] <= acc == `VPRU_ACC_KEYAB;
				stat_r[`VPRU_ST_LEN] <= len_bad;
				stat_r[`VPRU_ST_RO] <= acc == `VPRU_ACC_ROAB;
				stat_r[`VPRU_ST_MODE_MSB:`VPRU_ST_MODE_LSB] <= mode_idx;
				stat_r[`VPRU_ST_DSP] <= dsel;
				stat_r[`VPRU_ST_PAGE_MSB:`VPRU_ST_PAGE_LSB] <= vpage;
				fva_r <= cpu_vaddr;
			end
			else if (wstat)
				stat_r <= lane_merge(stat_r, s_axi_wdata, s_axi_wstrb) &
					~({15'h0000, 1'b1} << `VPRU_ST_TRAP);
		end
	end

	// write response: unmapped addresses answer with an error
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `VPRU_RESP_OK;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			if ((wtbl_hit & widx_ok) | s_axi_awaddr == `VPRU_CTRL_OFS |
				s_axi_awaddr == `VPRU_EXT_OFS | wstat |
				s_axi_awaddr == `VPRU_FVA_OFS)
				s_axi_bresp <= `VPRU_RESP_OK;
			else
				s_axi_bresp <= `VPRU_RESP_ERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read path: one registered answer per accepted address
	wire [5:0] ridx_bus = s_axi_araddr[7:2];
	wire [2:0] rtbl = s_axi_araddr[`VPRU_TBL_MSB:`VPRU_TBL_LSB];
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `VPRU_RESP_OK;
		end
		else if (rd_go)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `VPRU_RESP_OK;
			if (rtbl == 3'h0 && idx_in_range(s_axi_araddr))
				s_axi_rdata <= {16'h0000, base_mem[ridx_bus]};
			else if (rtbl == 3'h1 && idx_in_range(s_axi_araddr))
				s_axi_rdata <= {16'h0000, desc_mem[ridx_bus]};
			else if (s_axi_araddr == `VPRU_CTRL_OFS)
				s_axi_rdata <= {16'h0000, ctrl_r};
			else if (s_axi_araddr == `VPRU_EXT_OFS)
				s_axi_rdata <= {16'h0000, ext_r};
			else if (s_axi_araddr == `VPRU_STAT_OFS)
				s_axi_rdata <= {16'h0000, stat_r} |
					({31'h00000000, trap_pend_r} << `VPRU_ST_TRAP);
			else if (s_axi_araddr == `VPRU_FVA_OFS)
				s_axi_rdata <= {16'h0000, fva_r};
			else
			begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `VPRU_RESP_ERR;
			end
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule // vpru_top

`default_nettype wire

// file: verification/vpru_checker_properties.sv
// port checker for the relocation unit
`timescale 1ns/1ns
`default_nettype none
`include "vpru_defs.vh"
module vpru_checker
(
	// clock and reset
	input wire clk,
	input wire arst_n,
	// processor side
	input wire cpu_req,
	input wire [15:0] cpu_vaddr,
	input wire cpu_instr_end,
	// translated side
	input wire [21:0] phys_addr,
	input wire mem_req,
	input wire bus_req,
	input wire abort,
	input wire trap,
	input wire [15:0] fault_vector
);
	default clocking
		@(posedge clk);
	endclocking
	default disable iff (!arst_n);

	abort_gate_a: assert property (abort |-> !mem_req && !bus_req)
		else $error("request beside abort");
	bus_route_a: assert property (bus_req |-> phys_addr[21:18] == 4'hF)
		else $error("bus request off window");
	mem_route_a: assert property (mem_req |-> phys_addr[21:18] != 4'hF)
		else $error("memory request in bus window");
	ref_answer_a: assert property (
		cpu_req |=> $onehot({mem_req, bus_req, abort}))
		else $error("reference without one answer");
	idle_quiet_a: assert property (
		!cpu_req |=> !(mem_req || bus_req || abort))
		else $error("answer without reference");
	fault_vec_a: assert property (
		abort || trap |-> fault_vector == `VPRU_VECTOR)
		else $error("wrong fault vector");
	offset_pass_a: assert property (
		cpu_req |=> phys_addr[5:0] == $past(cpu_vaddr[5:0]))
		else $error("block offset altered");
	trap_late_a: assert property (trap |-> $past(cpu_instr_end))
		else $error("trap before instruction end");
endmodule // vpru_checker
`default_nettype wire

// file: verification/vpru_cpu_model.sv
// processor core model issuing references
`timescale 1ns/1ns
`default_nettype none
module vpru_cpu_model
(
	// clock
	input wire logic clk,
	// reference
	output logic req,
	output logic [15:0] vaddr,
	output logic [1:0] mode,
	output logic ispace,
	output logic write,
	output logic instr_end
);
	// quiet until the first reference
	initial
		{req, vaddr, mode, ispace, write, instr_end} = '0;

	// one reference; address is scrambled once it is no longer valid
	task automatic issue(input logic [1:0] m, input logic i, w,
		input logic [15:0] a);
		@(posedge clk);
		{req, mode, ispace, write, vaddr} <= {1'h1, m, i, w, a};
		@(posedge clk);
		req <= 1'h0;
		vaddr <= ~a;
	endtask

	// one-cycle instruction completion
	task automatic end_instr;
		@(posedge clk);
		instr_end <= 1'h1;
		@(posedge clk);
		instr_end <= 1'h0;
	endtask
endmodule // vpru_cpu_model
`default_nettype wire

// file: verification/vpru_top_tb.sv
// self-checking bench for the relocation unit
`timescale 1ns/1ns
`default_nettype none
`include "vpru_defs.vh"
module vpru_top_tb;
	logic clk = 1'h0;
	logic arst_n = 1'h0;
	wire cpu_req, cpu_ispace, cpu_write, cpu_instr_end;
	wire [15:0] cpu_vaddr, fault_vector;
	wire [1:0] cpu_mode, s_axi_bresp, s_axi_rresp;
	wire [21:0] phys_addr;
	wire mem_req, bus_req, ref_write, abort, trap;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	wire s_axi_awready, s_axi_wready, s_axi_arready;
	wire s_axi_bvalid, s_axi_rvalid;
	wire [31:0] s_axi_rdata;
	int n_mismatch = 0;
	int tests_run = 0;
	int cyc = 0;
	int tk[3] = '{1, 4, 5};

	vpru_cpu_model u_cpu (.clk, .req(cpu_req), .vaddr(cpu_vaddr),
		.mode(cpu_mode), .ispace(cpu_ispace), .write(cpu_write),
		.instr_end(cpu_instr_end));
	vpru_top u_dut (.clk, .arst_n, .cpu_req, .cpu_vaddr, .cpu_mode,
		.cpu_ispace, .cpu_write, .cpu_instr_end, .phys_addr, .mem_req,
		.bus_req, .ref_write, .abort, .trap, .fault_vector, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	// clock and hang guard
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			wrap_up;
		end
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, e);
		tests_run++;
		if (g !== e)
		begin
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
			n_mismatch++;
		end
	endtask

	// bus write; each channel is dropped at its own handshake
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, `VPRU_RESP_OK);
	endtask

	// bus read compared with an expected word and response
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, er);
	endtask

	// load one base and descriptor pair by table index
	task automatic map(input logic [11:0] x, input logic [31:0] b, v);
		wr(x << 2, b);
		wr(`VPRU_DESC_OFS + (x << 2), v);
	endtask

	// one reference; k is {abort, bus, memory}
	task automatic xr(input logic [1:0] m, input logic i, w,
		input logic [15:0] a, input logic [21:0] p, input logic [2:0] k);
		u_cpu.issue(m, i, w, a);
		#1;
		chk({abort, bus_req, mem_req}, k);
		chk(ref_write, w);
		if (!k[2])
			chk(phys_addr, p);
		else
			chk(fault_vector, `VPRU_VECTOR);
	endtask

	initial
	begin
		repeat (5) @(posedge clk);
		chk({abort, trap, mem_req, bus_req}, 0);
		arst_n <= 1'h1;
		rdchk(`VPRU_CTRL_OFS, 0, `VPRU_RESP_OK);
		rdchk(12'h500, 0, `VPRU_RESP_ERR);
		rdchk(12'h100, 0, `VPRU_RESP_ERR);
		xr(0, 1, 0, 16'h1234, 22'h001234, 1);
		xr(0, 0, 1, 16'hE010, 22'h3FE010, 2);
		wr(`VPRU_EXT_OFS, 32'h14);
		wr(`VPRU_CTRL_OFS, 32'h1);
		map(1, 32'h100, 32'h7F06);
		map(9, 32'h200, 32'h7F06);
		map(33, 32'h300, 32'h7F06);
		xr(0, 1, 0, 16'h20C5, 22'h0040C5, 1);
		xr(0, 0, 1, 16'h20C5, 22'h0080C5, 1);
		xr(3, 0, 0, 16'h20C5, 22'h00C0C5, 1);
		rdchk(12'h204, 32'h7F86, 0);
		rdchk(12'h224, 32'h7FC6, 0);
		map(2, 32'h100, 32'h7F02);
		xr(0, 1, 0, 16'h40C5, 22'h0040C5, 1);
		xr(0, 1, 1, 16'h4000, 0, 4);
		rdchk(12'h208, 32'h7F82, 0);
		rdchk(`VPRU_STAT_OFS, 32'h2004, 0);
		rdchk(`VPRU_FVA_OFS, 32'h4000, 0);
		wr(`VPRU_STAT_OFS, 0);
		map(3, 0, 32'h0206);
		xr(0, 1, 0, 16'h6080, 22'h000080, 1);
		xr(0, 1, 0, 16'h60C0, 0, 4);
		rdchk(`VPRU_STAT_OFS, 32'h4006, 0);
		wr(`VPRU_STAT_OFS, 0);
		map(4, 0, 32'h050E);
		xr(0, 1, 0, 16'h8140, 22'h000140, 1);
		xr(0, 1, 0, 16'h8100, 0, 4);
		wr(`VPRU_STAT_OFS, 0);
		// mid-run reset so the trap itself must load the vector
		arst_n <= 1'h0;
		@(posedge clk);
		chk({fault_vector, abort, trap}, 0);
		arst_n <= 1'h1;
		wr(`VPRU_CTRL_OFS, 32'h1);
		wr(`VPRU_EXT_OFS, 32'h14);
		foreach (tk[j])
		begin
			map(5, 32'h500, 32'h7F00 | tk[j]);
			xr(0, 1, tk[j] == 5, 16'hA000, 22'h014000, 1);
			chk(trap, 0);
			u_cpu.end_instr;
			#1;
			chk(trap, 1);
			chk(fault_vector, `VPRU_VECTOR);
		end
		map(6, 32'hFFF0, 32'h7F06);
		xr(0, 1, 0, 16'hC000, 22'h3FFC00, 2);
		map(7, 32'h2000, 32'h7F06);
		xr(0, 1, 0, 16'hE045, 22'h080045, 1);
		wr(`VPRU_EXT_OFS, 32'h04);
		xr(0, 1, 0, 16'hE045, 22'h000045, 1);
		wrap_up;
	end
endmodule // vpru_top_tb

bind vpru_top vpru_checker u_chk (.clk(clk), .arst_n(arst_n),
	.cpu_req(cpu_req), .cpu_vaddr(cpu_vaddr),
	.cpu_instr_end(cpu_instr_end), .phys_addr(phys_addr),
	.mem_req(mem_req), .bus_req(bus_req), .abort(abort), .trap(trap),
	.fault_vector(fault_vector));
`default_nettype wire
